// *** core/csb_params.svh ***
// constants for the compare, skip and branch execution block
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

`define CSB_PC_W        16
`define CSB_DATA_W      8
`define CSB_OFS_W       7
// status register flag positions
`define CSB_FLAG_C      0
`define CSB_FLAG_Z      1
`define CSB_FLAG_N      2
`define CSB_FLAG_V      3
`define CSB_FLAG_H      5
// program counter steps in words
`define CSB_PC_STEP_NEXT      16'h0001
`define CSB_PC_STEP_SKIP_ONE  16'h0002
`define CSB_PC_STEP_SKIP_TWO  16'h0003
// cycle costs
`define CSB_CYC_PLAIN         2'h1
`define CSB_CYC_SKIP_ONE      2'h2
`define CSB_CYC_SKIP_TWO      2'h3
`define CSB_CYC_BRANCH        2'h2
`define CSB_PC_RESET          16'h0000
`define CSB_STATUS_REGISTER_RESET        8'h00

`endif

// *** core/csb_pkg.sv ***
// types for the compare, skip and branch execution block
package csb_pkg;

	typedef enum logic [2:0] {
		OP_COMPARE_SKIP_EQUAL,
		OP_COMPARE_IMMEDIATE,
		OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLEAR
	} csb_op_t;

	typedef enum logic {
		ST_IDLE,
		ST_WAIT
	} csb_state_t;

endpackage

// *** core/csb_sub_flags.sv ***
// subtract-without-store flag generator for the compare with immediate
`timescale 1ns/1ps
`include "csb_params.svh"

module csb_sub_flags (
	// operands
	input  wire logic [`CSB_DATA_W-1:0] minuend,
	input  wire logic [`CSB_DATA_W-1:0] subtrahend,
	// flags
	output logic                        flag_z,
	output logic                        flag_n,
	output logic                        flag_v,
	output logic                        flag_c,
	output logic                        flag_h
);

	logic [`CSB_DATA_W-1:0] diff;

	// the difference is only looked at, never written back
	always_comb begin
		diff   = minuend - subtrahend;
		flag_z = (diff == 8'h00);
		flag_n = diff[7];
		flag_v = (minuend[7] & ~subtrahend[7] & ~diff[7])
			| (~minuend[7] & subtrahend[7] & diff[7]);
		flag_c = (minuend < subtrahend);
		flag_h = (minuend[3:0] < subtrahend[3:0]);
	end

endmodule // csb_sub_flags

// *** core/csb_exec.sv ***
// execution of compare, conditional skip and conditional branch instructions
`timescale 1ns/1ps
`include "csb_params.svh"

module csb_exec (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// instruction request
	input  wire logic                   start,
	input  csb_pkg::csb_op_t            op,
	input  wire logic                   next_two_word,
	input  wire logic [`CSB_PC_W-1:0]   pc_in,
	// operands
	input  wire logic [`CSB_DATA_W-1:0] opnd_d,
	input  wire logic [`CSB_DATA_W-1:0] opnd_r,
	input  wire logic [`CSB_DATA_W-1:0] imm_k,
	input  wire logic [2:0]             bit_sel,
	input  wire logic [`CSB_DATA_W-1:0] io_data,
	input  wire logic [2:0]             flag_sel,
	input  wire logic [`CSB_OFS_W-1:0]  offset_k,
	input  wire logic [`CSB_DATA_W-1:0] status_register_in,
	// results
	output logic                        busy_r,
	output logic                        done_r,
	output logic [`CSB_PC_W-1:0]        pc_out_r,
	output logic [`CSB_DATA_W-1:0]      status_register_out_r,
	output logic                        status_we_r,
	output logic [1:0]                  cycles_r
);

	csb_pkg::csb_state_t state_r;
	csb_pkg::csb_state_t state_nxt;
	logic [1:0]                  cnt_r;
	logic [1:0]                  cnt_nxt;
	logic                        busy_nxt;
	logic                        done_nxt;
	logic [`CSB_PC_W-1:0]        pc_out_nxt;
	logic [`CSB_DATA_W-1:0]      status_register_nxt;
	logic                        status_we_nxt;
	logic [1:0]                  cycles_nxt;

	logic                        fz, fn, fv, fc, fh;
	logic                        skip;
	logic                        branch;
	logic [1:0]                  cost;
	logic [`CSB_PC_W-1:0]        pc_target;
	logic [`CSB_PC_W-1:0]        pc_branch;
	logic [`CSB_DATA_W-1:0]      status_register_cmp;
	logic                        accept;

	csb_sub_flags u_flags (
		.minuend    (opnd_d),
		.subtrahend (imm_k),
		.flag_z     (fz),
		.flag_n     (fn),
		.flag_v     (fv),
		.flag_c     (fc),
		.flag_h     (fh)
	);

	assign accept    = start && !busy_r;
	assign pc_branch = pc_in + {{(`CSB_PC_W-`CSB_OFS_W){offset_k[`CSB_OFS_W-1]}}, offset_k}
		+ `CSB_PC_STEP_NEXT;

	// outcome of the instruction presented this cycle
	always_comb begin
		skip   = 1'b0;
		branch = 1'b0;
		unique case (op)
			csb_pkg::OP_COMPARE_SKIP_EQUAL: skip = (opnd_d == opnd_r);
			csb_pkg::OP_COMPARE_IMMEDIATE:  skip = 1'b0;
			csb_pkg::OP_SKIP_REG_BIT_CLEAR: skip = !opnd_r[bit_sel];
			csb_pkg::OP_SKIP_REG_BIT_SET:   skip = opnd_r[bit_sel];
			csb_pkg::OP_SKIP_IO_BIT_CLEAR:  skip = !io_data[bit_sel];
			csb_pkg::OP_SKIP_IO_BIT_SET:    skip = io_data[bit_sel];
			csb_pkg::OP_BRANCH_FLAG_SET:    branch = status_register_in[flag_sel];
			csb_pkg::OP_BRANCH_FLAG_CLEAR:  branch = !status_register_in[flag_sel];
		endcase
		// length of the skipped word decides the step and the cost
		if (skip && next_two_word) begin
			pc_target = pc_in + `CSB_PC_STEP_SKIP_TWO;
			cost      = `CSB_CYC_SKIP_TWO;
		end else if (skip) begin
			pc_target = pc_in + `CSB_PC_STEP_SKIP_ONE;
			cost      = `CSB_CYC_SKIP_ONE;
		end else if (branch) begin
			pc_target = pc_branch;
			cost      = `CSB_CYC_BRANCH;
		end else begin
			pc_target = pc_in + `CSB_PC_STEP_NEXT;
			cost      = `CSB_CYC_PLAIN;
		end
		// only the compare with immediate touches flags; everything else passes them through
		status_register_cmp = status_register_in;
		if (op == csb_pkg::OP_COMPARE_IMMEDIATE) begin
			status_register_cmp[`CSB_FLAG_Z] = fz;
			status_register_cmp[`CSB_FLAG_N] = fn;
			status_register_cmp[`CSB_FLAG_V] = fv;
			status_register_cmp[`CSB_FLAG_C] = fc;
			status_register_cmp[`CSB_FLAG_H] = fh;
		end
	end

	// sequencer: next pc and flags are registered on taking; done is held back until the cost in cycles has run out
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		busy_nxt      = busy_r;
		done_nxt      = 1'b0;
		pc_out_nxt    = pc_out_r;
		status_register_nxt      = status_register_out_r;
		status_we_nxt = 1'b0;
		cycles_nxt    = cycles_r;
		unique case (state_r)
			csb_pkg::ST_IDLE: begin
				if (accept) begin
					pc_out_nxt = pc_target;
					status_register_nxt   = status_register_cmp;
					cycles_nxt = cost;
					if (cost == `CSB_CYC_PLAIN) begin
						done_nxt      = 1'b1;
						status_we_nxt = (op == csb_pkg::OP_COMPARE_IMMEDIATE);
					end else begin
						state_nxt = csb_pkg::ST_WAIT;
						cnt_nxt   = cost - 2'h1;
						busy_nxt  = 1'b1;
					end
				end
			end
			csb_pkg::ST_WAIT: begin
				cnt_nxt = cnt_r - 2'h1;
				if (cnt_r == 2'h1) begin
					state_nxt = csb_pkg::ST_IDLE;
					busy_nxt  = 1'b0;
					done_nxt  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r               <= csb_pkg::ST_IDLE;
			cnt_r                 <= 2'h0;
			busy_r                <= 1'b0;
			done_r                <= 1'b0;
			pc_out_r              <= `CSB_PC_RESET;
			status_register_out_r <= `CSB_STATUS_REGISTER_RESET;
			status_we_r           <= 1'b0;
			cycles_r              <= 2'h0;
		end else begin
			state_r               <= state_nxt;
			cnt_r                 <= cnt_nxt;
			busy_r                <= busy_nxt;
			done_r                <= done_nxt;
			pc_out_r              <= pc_out_nxt;
			status_register_out_r <= status_register_nxt;
			status_we_r           <= status_we_nxt;
			cycles_r              <= cycles_nxt;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_cmp_skip_one;
		accept && op == csb_pkg::OP_COMPARE_SKIP_EQUAL && opnd_d == opnd_r && !next_two_word
		|=> !done_r ##1 (done_r && pc_out_r == $past(pc_in, 2) + 16'h0002 && !status_we_r);
	endproperty
	a_cmp_skip_one: assert property (p_cmp_skip_one) else $error("equal compare skip wrong");

	property p_cmp_no_skip;
		accept && op == csb_pkg::OP_COMPARE_SKIP_EQUAL && opnd_d != opnd_r
		|=> done_r && pc_out_r == $past(pc_in) + 16'h0001 && cycles_r == 2'h1;
	endproperty
	a_cmp_no_skip: assert property (p_cmp_no_skip) else $error("unequal compare skipped");

	property p_cmp_imm;
		accept && op == csb_pkg::OP_COMPARE_IMMEDIATE
		|=> done_r && status_we_r
			&& status_register_out_r[`CSB_FLAG_Z] == ($past(opnd_d) == $past(imm_k))
			&& status_register_out_r[`CSB_FLAG_C] == ($past(opnd_d) < $past(imm_k));
	endproperty
	a_cmp_imm: assert property (p_cmp_imm) else $error("immediate compare flags wrong");

	property p_reg_clear_two;
		accept && op == csb_pkg::OP_SKIP_REG_BIT_CLEAR && !opnd_r[bit_sel] && next_two_word
		|=> (!done_r && busy_r) [*2] ##1 (done_r && pc_out_r == $past(pc_in, 3) + 16'h0003);
	endproperty
	a_reg_clear_two: assert property (p_reg_clear_two) else $error("two-word skip wrong");

	property p_reg_set;
		accept && op == csb_pkg::OP_SKIP_REG_BIT_SET && opnd_r[bit_sel] && !next_two_word
		|-> ##2 (done_r && pc_out_r == $past(pc_in, 2) + 16'h0002 && cycles_r == 2'h2);
	endproperty
	a_reg_set: assert property (p_reg_set) else $error("register bit set skip wrong");

	// flags are settled at the edge after taking and held until the next request is taken
	property p_io_clear_flags;
		accept && op == csb_pkg::OP_SKIP_IO_BIT_CLEAR
		|=> !status_we_r && status_register_out_r == $past(status_register_in);
	endproperty
	a_io_clear_flags: assert property (p_io_clear_flags) else $error("io skip touched flags");

	property p_io_set_none;
		accept && op == csb_pkg::OP_SKIP_IO_BIT_SET && !io_data[bit_sel]
		|=> done_r && pc_out_r == $past(pc_in) + 16'h0001;
	endproperty
	a_io_set_none: assert property (p_io_set_none) else $error("io skip without bit set");

	property p_branch_set;
		accept && op == csb_pkg::OP_BRANCH_FLAG_SET && status_register_in[flag_sel]
		|=> !done_r ##1 (done_r && !status_we_r
			&& pc_out_r == $past(pc_in, 2) + 16'(signed'($past(offset_k, 2))) + 16'h0001);
	endproperty
	a_branch_set: assert property (p_branch_set) else $error("branch on set flag wrong");

	property p_branch_clear_fall;
		accept && op == csb_pkg::OP_BRANCH_FLAG_CLEAR && status_register_in[flag_sel]
		|=> done_r && pc_out_r == $past(pc_in) + 16'h0001 && cycles_r == 2'h1;
	endproperty
	a_branch_clear_fall: assert property (p_branch_clear_fall) else $error("branch taken wrongly");

	property p_skip_cost;
		done_r && cycles_r == 2'h3 |-> $past(busy_r) && $past(busy_r, 2) && !$past(busy_r, 3);
	endproperty
	a_skip_cost: assert property (p_skip_cost) else $error("three-cycle cost miscounted");

	c_skip_two: cover property (accept && skip && next_two_word ##3 done_r);
	c_branch_taken: cover property (accept && branch ##2 done_r);
	c_cmp_imm: cover property (accept && op == csb_pkg::OP_COMPARE_IMMEDIATE ##1 status_we_r);
	c_back_to_back: cover property (done_r && accept);

endmodule // csb_exec

// *** verif/testbench.sv ***
// self-checking bench for the compare, skip and branch execution block
`timescale 1ns/1ps
`include "csb_params.svh"

module testbench;
	typedef struct {
		logic [15:0] pc;
		logic [7:0]  status_register;
		logic        we;
		logic [1:0]  cyc;
		int          due;
	} csb_note_t;

	logic                   mclk               = 1'b0;
	logic                   rst                = 1'b1;
	logic                   start              = 1'b0;
	csb_pkg::csb_op_t       op                 = csb_pkg::OP_COMPARE_IMMEDIATE;
	logic                   next_two_word      = 1'b0;
	logic [`CSB_PC_W-1:0]   pc_in              = 16'h0000;
	logic [`CSB_DATA_W-1:0] opnd_d             = 8'h00;
	logic [`CSB_DATA_W-1:0] opnd_r             = 8'h00;
	logic [`CSB_DATA_W-1:0] imm_k              = 8'h00;
	logic [2:0]             bit_sel            = 3'h0;
	logic [`CSB_DATA_W-1:0] io_data            = 8'h00;
	logic [2:0]             flag_sel           = 3'h0;
	logic [`CSB_OFS_W-1:0]  offset_k           = 7'h00;
	logic [`CSB_DATA_W-1:0] status_register_in = 8'h00;
	logic                   busy_r;
	logic                   done_r;
	logic [`CSB_PC_W-1:0]   pc_out_r;
	logic [`CSB_DATA_W-1:0] status_register_out_r;
	logic                   status_we_r;
	logic [1:0]             cycles_r;
	csb_note_t              notes[$];
	int                     miscompares        = 0;
	int                     checks             = 0;
	int                     cyc                = 0;
	int                     seed               = 32'h8fec;

	csb_exec csb_exec_i (.mclk(mclk), .rst(rst), .start(start), .op(op),
		.next_two_word(next_two_word), .pc_in(pc_in), .opnd_d(opnd_d), .opnd_r(opnd_r),
		.imm_k(imm_k), .bit_sel(bit_sel), .io_data(io_data), .flag_sel(flag_sel),
		.offset_k(offset_k), .status_register_in(status_register_in), .busy_r(busy_r),
		.done_r(done_r), .pc_out_r(pc_out_r), .status_register_out_r(status_register_out_r),
		.status_we_r(status_we_r), .cycles_r(cycles_r));

	always #12.5 mclk = ~mclk;

	always @(posedge mclk) cyc <= cyc + 1;

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_time(input int got, input int exp);
		checks++;
		if (got != exp) begin
			miscompares++;
			$display("MISMATCH at %0t: timing got %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic idle;
		start <= 1'b0;
		@(posedge mclk);
	endtask

	// called just after an edge; returns at the edge of the done cycle so starts run back to back
	task automatic issue;
		csb_note_t        n;
		csb_pkg::csb_op_t o;
		logic [7:0]       d, r, k, io, sr, df;
		logic [2:0]       b, f;
		logic [6:0]       ofs;
		logic [15:0]      p;
		logic             two, skip, br;
		o = csb_pkg::csb_op_t'(3'($random(seed)));
		{d, r, k, io} = 32'($random(seed));
		{sr, b, f, ofs, two} = 22'($random(seed));
		p = 16'($random(seed));
		// equal operands are rare when random, so force them half the time
		if ($random(seed) & 1) begin
			r = d;
			k = d;
		end
		df = d - k;
		skip = 1'b0;
		br = 1'b0;
		n.status_register = sr;
		n.we = 1'b0;
		case (o)
			csb_pkg::OP_COMPARE_SKIP_EQUAL: skip = (d == r);
			csb_pkg::OP_COMPARE_IMMEDIATE: begin
				n.we = 1'b1;
				n.status_register[`CSB_FLAG_Z] = (df == 8'h00);
				n.status_register[`CSB_FLAG_N] = df[7];
				n.status_register[`CSB_FLAG_V] = (d[7] & ~k[7] & ~df[7]) | (~d[7] & k[7] & df[7]);
				n.status_register[`CSB_FLAG_C] = (d < k);
				n.status_register[`CSB_FLAG_H] = (d[3:0] < k[3:0]);
			end
			csb_pkg::OP_SKIP_REG_BIT_CLEAR: skip = ~r[b];
			csb_pkg::OP_SKIP_REG_BIT_SET: skip = r[b];
			csb_pkg::OP_SKIP_IO_BIT_CLEAR: skip = ~io[b];
			csb_pkg::OP_SKIP_IO_BIT_SET: skip = io[b];
			csb_pkg::OP_BRANCH_FLAG_SET: br = sr[f];
			default: br = ~sr[f];
		endcase
		n.pc = p + 16'h0001;
		n.cyc = 2'h1;
		if (skip) begin
			n.pc = p + (two ? 16'h0003 : 16'h0002);
			n.cyc = two ? 2'h3 : 2'h2;
		end
		if (br) begin
			n.pc = p + {{9{ofs[6]}}, ofs} + 16'h0001;
			n.cyc = 2'h2;
		end
		n.due = cyc + 1 + n.cyc;
		notes.push_back(n);
		start <= 1'b1;
		op <= o;
		next_two_word <= two;
		pc_in <= p;
		opnd_d <= d;
		opnd_r <= r;
		imm_k <= k;
		bit_sel <= b;
		io_data <= io;
		flag_sel <= f;
		offset_k <= ofs;
		status_register_in <= sr;
		repeat (n.cyc) @(posedge mclk);
	endtask

	always @(negedge mclk) begin : mon
		csb_note_t n;
		logic      exp_busy;
		exp_busy = 1'b0;
		if (!rst && done_r === 1'b1) begin
			if (notes.size() == 0)
				chk_val(16'h0001, 16'h0000, "unexpected done");
			else begin
				n = notes.pop_front();
				chk_time(cyc, n.due);
				chk_val(pc_out_r, n.pc, "next pc");
				chk_val(16'(status_register_out_r), 16'(n.status_register), "status");
				chk_val(16'(status_we_r), 16'(n.we), "status write");
				chk_val(16'(cycles_r), 16'(n.cyc), "cost");
				chk_val(16'(busy_r), 16'h0000, "busy at done");
			end
		end else if (notes.size() > 0 && cyc > notes[0].due) begin
			chk_time(cyc, notes[0].due);
			results();
		end else if (!rst) begin
			// busy only in the wait cycles between taking and done
			if (notes.size() > 0)
				exp_busy = cyc > notes[0].due - notes[0].cyc && cyc < notes[0].due;
			chk_val(16'(busy_r), 16'(exp_busy), "busy");
		end
	end

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk_val(pc_out_r, 16'h0000, "reset pc");
		chk_val(16'({busy_r, done_r, status_we_r, cycles_r, status_register_out_r}), 16'h0000, "reset");
		@(posedge mclk);
		for (int i = 0; i < 400; i++) begin
			if (($random(seed) & 7) == 0)
				idle();
			issue();
		end
		idle();
		repeat (4) @(posedge mclk);
		chk_time(notes.size(), 0);
		results();
	end
endmodule // testbench
